/* core/mprs_consts.svh */
// Constants for the module power and reset sequencer
// Overview of operation
// - Power control high requests power-on and boot
// - Low hard restart input also powers on
// - Restart held low over 1 s restarts
// - Host uses hard restart only for emergencies
// - Active state no sooner than 50 s
// - Host waits for activation before talking
// - Power control may rise with supply
// - Boot-done high after boot when enabled
// - Power control low starts graceful finalization
// - Rail output signals ready after finalization
// - Trigger GPIO falling edge starts fast shutdown
// - Fast shutdown disabled until software enables
// - Off indicator optional, disabled by default
// - After fast shutdown with indicator, stay off
// - Host holds power control low without indicator
// - Supply kept without indicator means reboot
// - Host drives no highs while module off
// - Rail active when on, off when down
// - Port select sampled at power-on start
`ifndef MPRS_CONSTS_SVH
`define MPRS_CONSTS_SVH
`define MPRS_CLK_HZ        40000000
`define MPRS_RESTART_MS    1000
`define MPRS_BOOT_S        50
`define MPRS_RESTART_CYC   ((`MPRS_CLK_HZ / 1000) * `MPRS_RESTART_MS + 1)
`define MPRS_BOOT_CYC      (`MPRS_CLK_HZ * `MPRS_BOOT_S)
`define MPRS_FINAL_CYC     64
`define MPRS_CNT_W         32
`endif

/* core/mprs_pkg.sv */
// Types for the module power and reset sequencer
package mprs_pkg;
    typedef enum logic [4:0] {
        MPRS_OFF    = 5'h01,
        MPRS_BOOT   = 5'h02,
        MPRS_ACTIVE = 5'h04,
        MPRS_FINAL  = 5'h08,
        MPRS_HALT   = 5'h10
    } mprs_state_t;
    typedef enum logic [0:0] {
        MPRS_PORT_PCIE   = 1'b0,
        MPRS_PORT_SERIAL = 1'b1
    } mprs_port_t;
endpackage

/* core/mprs_if.sv */
// Power control pins between host and module
`timescale 1ns/1ps
`default_nettype none
interface mprs_if;
    logic power_ctrl;
    logic restart_oe;
    logic hard_restart_input;
    logic port_sel;
    logic sel_oe;
    logic fast_trig;
    logic reference_rail_output;
    logic boot_done;
    assign hard_restart_input = ~restart_oe;
    assign port_sel           = ~sel_oe;
    modport dev
    (
        input  power_ctrl, hard_restart_input, port_sel, fast_trig,
        output reference_rail_output, boot_done
    );
    modport host
    (
        output power_ctrl, restart_oe, sel_oe, fast_trig,
        input  reference_rail_output, boot_done
    );
endinterface
`default_nettype wire

/* core/mprs_device.sv */
// Module end: power, boot, shutdown and restart sequencing
`timescale 1ns/1ps
`default_nettype none
`include "mprs_consts.svh"
module mprs_device
#(
    parameter logic [31:0] BOOT_CYC    = `MPRS_BOOT_CYC,
    parameter logic [31:0] RESTART_CYC = `MPRS_RESTART_CYC,
    parameter logic [31:0] FINAL_CYC   = `MPRS_FINAL_CYC
)
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic           clk_en,
    // Pins
    mprs_if.dev                 pins,
    // Software configuration and main supply
    input  wire logic           off_state_indicator_func,
    input  wire logic           fast_off_en,
    input  wire logic           main_supply,
    // Status
    output mprs_pkg::mprs_state_t state,
    output mprs_pkg::mprs_port_t  host_port,
    output logic                restart_pulse
);
    import mprs_pkg::*;

    logic [1:0]  pwr_s_q, rst_s_q, trig_s_q, sel_s_q;
    logic        trig_prev_q;
    logic [31:0] boot_cnt_q, rst_cnt_q, fin_cnt_q;
    logic        rst_long_q, restart_q, rail_q, done_q, latch_q;
    mprs_state_t state_q;
    mprs_port_t  port_q;
    logic        pwr, rst_lo, trig_fall, power_req;
    logic        boot_start;

    function automatic logic [31:0] inc_sat(input logic [31:0] v);
        inc_sat = (v == 32'hffffffff) ? v : v + 32'h1;
    endfunction

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_s_q  <= 2'h0;
            rst_s_q  <= 2'h3;
            trig_s_q <= 2'h3;
            sel_s_q  <= 2'h3;
        end
        else if (clk_en)
        begin
            pwr_s_q  <= {pwr_s_q[0], pins.power_ctrl};
            rst_s_q  <= {rst_s_q[0], pins.hard_restart_input};
            trig_s_q <= {trig_s_q[0], pins.fast_trig};
            sel_s_q  <= {sel_s_q[0], pins.port_sel};
        end
    end

    assign pwr       = pwr_s_q[1];
    assign rst_lo    = ~rst_s_q[1];
    assign trig_fall = trig_prev_q & ~trig_s_q[1] & fast_off_en;
    assign power_req = main_supply & (pwr | rst_lo);
    assign boot_start = power_req && !latch_q;

    // Restart low-time counter
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt_q  <= 32'h0;
            rst_long_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rst_lo)
            begin
                rst_cnt_q <= inc_sat(rst_cnt_q);
                if (rst_cnt_q >= RESTART_CYC - 32'h1)
                    rst_long_q <= 1'b1;
            end
            else
            begin
                rst_cnt_q  <= 32'h0;
                rst_long_q <= 1'b0;
            end
        end
    end

    // One-cycle restart pulse on release of a long low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            restart_q <= 1'b0;
        else if (clk_en)
            restart_q <= rst_long_q && !rst_lo;
    end

    // Trigger edge memory
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            trig_prev_q <= 1'b1;
        else if (clk_en)
            trig_prev_q <= trig_s_q[1];
    end

    // Power state machine
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= MPRS_OFF;
            boot_cnt_q <= 32'h0;
            fin_cnt_q  <= 32'h0;
            latch_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!main_supply)
            begin
                state_q <= MPRS_OFF;
                latch_q <= 1'b0;
            end
            else if (restart_q)
            begin
                state_q    <= MPRS_BOOT;
                boot_cnt_q <= 32'h0;
                latch_q    <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    MPRS_OFF:
                        if (boot_start)
                        begin
                            state_q    <= MPRS_BOOT;
                            boot_cnt_q <= 32'h0;
                        end
                    MPRS_BOOT:
                        if (!pwr && !rst_lo)
                        begin
                            state_q   <= MPRS_FINAL;
                            fin_cnt_q <= 32'h0;
                            latch_q   <= trig_fall & off_state_indicator_func;
                        end
                        else if (boot_cnt_q >= BOOT_CYC - 32'h1)
                            state_q <= MPRS_ACTIVE;
                        else
                            boot_cnt_q <= boot_cnt_q + 32'h1;
                    MPRS_ACTIVE:
                        if (!pwr || trig_fall)
                        begin
                            state_q   <= MPRS_FINAL;
                            fin_cnt_q <= 32'h0;
                            latch_q   <= trig_fall & off_state_indicator_func;
                        end
                    MPRS_FINAL:
                        if (fin_cnt_q >= FINAL_CYC - 32'h1)
                            state_q <= MPRS_HALT;
                        else
                            fin_cnt_q <= fin_cnt_q + 32'h1;
                    MPRS_HALT:
                        if (!latch_q)
                            state_q <= MPRS_OFF;
                    default:
                        state_q <= MPRS_OFF;
                endcase
            end
        end
    end

    // Host port choice, latched as each boot starts
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            port_q <= MPRS_PORT_SERIAL;
        else if (clk_en && main_supply)
        begin
            if (restart_q || ((state_q == MPRS_OFF) && boot_start))
                port_q <= mprs_port_t'(sel_s_q[1]);
        end
    end

    // Reference rail drive
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rail_q <= 1'b0;
        else if (clk_en)
            rail_q <= (state_q == MPRS_BOOT) || (state_q == MPRS_ACTIVE)
                   || (state_q == MPRS_FINAL);
    end

    // Boot-done drive
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            done_q <= 1'b0;
        else if (clk_en)
            done_q <= off_state_indicator_func
                   && (state_q == MPRS_ACTIVE);
    end

    assign pins.reference_rail_output = rail_q;
    assign pins.boot_done             = done_q;
    assign state                      = state_q;
    assign host_port                  = port_q;
    assign restart_pulse              = restart_q;
endmodule
`default_nettype wire

/* core/mprs_host.sv */
// Host end: drives power control, restart, port select, trigger
`timescale 1ns/1ps
`default_nettype none
`include "mprs_consts.svh"
module mprs_host
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Pins
    mprs_if.host      pins,
    // User side
    input  wire logic want_on,
    input  wire logic want_restart,
    input  wire logic use_pcie,
    input  wire logic fast_off,
    output logic      module_up,
    output logic      module_ready
);
    import mprs_pkg::*;

    logic       on_q, oe_q, sel_q, trig_q;
    logic [1:0] rail_s_q, done_s_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            on_q   <= 1'b0;
            oe_q   <= 1'b0;
            sel_q  <= 1'b1;
            trig_q <= 1'b1;
        end
        else if (clk_en)
        begin
            on_q   <= want_on;
            oe_q   <= want_restart;
            sel_q  <= ~use_pcie;
            trig_q <= ~fast_off;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail_s_q <= 2'h0;
            done_s_q <= 2'h0;
        end
        else if (clk_en)
        begin
            rail_s_q <= {rail_s_q[0], pins.reference_rail_output};
            done_s_q <= {done_s_q[0], pins.boot_done};
        end
    end

    assign pins.power_ctrl = on_q;
    assign pins.restart_oe = oe_q;
    assign pins.sel_oe     = ~sel_q;
    assign pins.fast_trig  = trig_q & rail_s_q[1];
    assign module_up       = rail_s_q[1];
    assign module_ready    = done_s_q[1];
endmodule
`default_nettype wire

/* test/mprs_asserts.sv */
// Checker on the host to module power pins
`timescale 1ns/1ps
`default_nettype none
module mprs_asserts
#(
    parameter int BOOT_CYC    = 100,
    parameter int RESTART_CYC = 20
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pins
    input wire logic power_ctrl,
    input wire logic hard_restart_input,
    input wire logic fast_trig,
    input wire logic reference_rail_output,
    input wire logic boot_done
);
    int on_q;
    int lo_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles since rail came up or boot restarted
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n || !reference_rail_output || $fell(boot_done))
            on_q <= 0;
        else
            on_q <= on_q + 1;
    // Cycles the restart pin has been low
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n || hard_restart_input)
            lo_q <= 0;
        else
            lo_q <= lo_q + 1;
    AST_RAIL_ON: assert property (
        $rose(power_ctrl) && !reference_rail_output && hard_restart_input
        |-> ##[1:8] reference_rail_output) else $error("rail late");
    AST_BOOT_MIN: assert property (
        $rose(boot_done) |-> on_q >= BOOT_CYC - 4) else $error("boot early");
    AST_BOOT_RAIL: assert property (
        boot_done |-> reference_rail_output) else $error("done no rail");
    AST_GRACE_HOLD: assert property (
        $fell(power_ctrl) && reference_rail_output
        |-> reference_rail_output[*8]) else $error("rail cut short");
    AST_GRACE_OFF: assert property (
        $fell(power_ctrl) && reference_rail_output
        |-> ##[9:30] !reference_rail_output) else $error("rail stuck");
    AST_RST_SHORT: assert property (
        $rose(hard_restart_input) && lo_q < RESTART_CYC - 2 && boot_done
        |-> boot_done[*6]) else $error("short pulse acted");
    AST_RST_LONG: assert property (
        $rose(hard_restart_input) && lo_q > RESTART_CYC + 2 && boot_done
        |-> ##[1:8] !boot_done) else $error("no restart");
    AST_HOST_QUIET: assert property (
        (!reference_rail_output)[*4] |-> !fast_trig)
        else $error("host drove high");
endmodule
`default_nettype wire

/* test/tb.sv */
// Testbench joining host and module ends of the power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mprs_pkg::*;
    localparam int BC = 100;
    localparam int RC = 20;
    logic mclk, rst_n, want_on, want_restart, use_pcie, fast_off;
    logic ind, fast_en, supply, rp, rdy, up;
    mprs_state_t st;
    mprs_port_t hp;
    int fails, samples_checked, pulses, cyc, n;
    mprs_if pins();
    mprs_device #(.BOOT_CYC(BC), .RESTART_CYC(RC), .FINAL_CYC(8))
        mprs_device_inst (.mclk, .rst_n, .clk_en(1'b1), .pins(pins),
        .off_state_indicator_func(ind), .fast_off_en(fast_en),
        .main_supply(supply), .state(st), .host_port(hp), .restart_pulse(rp));
    mprs_host mprs_host_inst (.mclk, .rst_n, .clk_en(1'b1), .pins(pins),
        .want_on, .want_restart, .use_pcie, .fast_off, .module_up(up),
        .module_ready(rdy));
    mprs_asserts #(.BOOT_CYC(BC), .RESTART_CYC(RC)) mprs_asserts_inst (
        .mclk, .rst_n, .power_ctrl(pins.power_ctrl),
        .hard_restart_input(pins.hard_restart_input),
        .fast_trig(pins.fast_trig),
        .reference_rail_output(pins.reference_rail_output),
        .boot_done(pins.boot_done));
    task conclude;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task wst(input mprs_state_t s, input int lim);
        n = 0;
        while (st !== s && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask
    task rs(input int k);
        want_restart = 1;
        tick(k);
        want_restart = 0;
    endtask
    task s_boot(input logic p, input logic i);
        use_pcie = p;
        ind = i;
        supply = 1;
        want_on = 1;
        wst(MPRS_ACTIVE, 400);
        chk(st, MPRS_ACTIVE);
        chk(n >= BC, 1);
        tick(6);
        chk(pins.boot_done, i);
        chk(rdy, i);
        chk(up, 1);
        chk(hp, p ? MPRS_PORT_PCIE : MPRS_PORT_SERIAL);
    endtask
    task s_fast_dis;
        fast_off = 1;
        tick(30);
        chk(st, MPRS_ACTIVE);
        fast_off = 0;
        tick(5);
    endtask
    task s_grace;
        want_on = 0;
        wst(MPRS_FINAL, 20);
        chk(pins.reference_rail_output, 1);
        wst(MPRS_OFF, 40);
        chk(pins.reference_rail_output, 0);
        tick(20);
        chk(st, MPRS_OFF);
    endtask
    task s_short;
        rs(RC - 5);
        tick(10);
        chk(st, MPRS_ACTIVE);
        chk(pulses, 0);
    endtask
    task s_fast_ind;
        fast_en = 1;
        fast_off = 1;
        wst(MPRS_HALT, 40);
        tick(50);
        chk(st, MPRS_HALT);
        chk(pins.reference_rail_output, 0);
        chk(up, 0);
        fast_off = 0;
    endtask
    task s_long;
        repeat (2)
        begin
            rs(RC + 5);
            wst(MPRS_BOOT, 20);
            chk(st, MPRS_BOOT);
            wst(MPRS_ACTIVE, 400);
            tick(6);
        end
        chk(pulses, 2);
    endtask
    task s_fast_noind;
        ind = 0;
        fast_off = 1;
        wst(MPRS_FINAL, 20);
        chk(st, MPRS_FINAL);
        fast_off = 0;
        wst(MPRS_BOOT, 60);
        chk(st, MPRS_BOOT);
        wst(MPRS_ACTIVE, 400);
    endtask
    task s_wake;
        rs(4);
        wst(MPRS_BOOT, 10);
        chk(st, MPRS_BOOT);
    endtask
    initial
    begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    always @(negedge mclk)
    begin
        cyc++;
        if (rp === 1'b1)
            pulses++;
        if (cyc == 5000)
        begin
            fails++;
            conclude();
        end
    end
    initial
    begin
        {want_on, want_restart, use_pcie, fast_off, ind, fast_en} = '0;
        supply = 0;
        rst_n = 0;
        tick(2);
        rst_n = 1;
        tick(2);
        s_boot(1, 0);
        s_fast_dis();
        s_grace();
        s_boot(0, 1);
        s_short();
        s_fast_ind();
        s_long();
        s_fast_noind();
        s_grace();
        s_wake();
        conclude();
    end
endmodule
`default_nettype wire
